// >>> core/fsp_pkg.sv
// Constants shared by the flash self-programming sequencer files
`default_nettype none
package fsp_pkg;
   // ------------------------------------------------------------------
   // Register offsets on the local register port
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL = 4'h0; // access control
   localparam logic [3:0] OFS_MODE = 4'h1; // mode select
   localparam logic [3:0] OFS_ADDR_HI = 4'h2; // flash address high byte
   localparam logic [3:0] OFS_ADDR_LO = 4'h3; // flash address low byte
   localparam logic [3:0] OFS_DATA = 4'h4; // flash data
   localparam logic [3:0] OFS_CMD = 4'h5; // command trigger
   localparam logic [3:0] OFS_LB_HI = 4'h6; // data region low bound high
   localparam logic [3:0] OFS_LB_LO = 4'h7; // data region low bound low
   localparam logic [3:0] OFS_STATUS = 4'h8; // sequencer status

   // ------------------------------------------------------------------
   // Field positions and codes
   // ------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 7; // flash_access_enable
   localparam int CTRL_CODE_HI = 7; // software reset code field top
   localparam int CTRL_CODE_LO = 5; // software reset code field bottom
   localparam logic [2:0] SWRST_TO_APP = 3'h1; // reboot at app start
   localparam logic [2:0] SWRST_TO_LOADER = 3'h7; // reboot into loader
   localparam logic [7:0] MODE_STANDBY = 8'h00;
   localparam logic [7:0] MODE_READ = 8'h01;
   localparam logic [7:0] MODE_PROGRAM = 8'h02;
   localparam logic [7:0] MODE_ERASE = 8'h03;
   localparam logic [7:0] CMD_UNLOCK_1 = 8'h46;
   localparam logic [7:0] CMD_UNLOCK_2 = 8'hb9;

   // ------------------------------------------------------------------
   // Flash geometry and partition
   // ------------------------------------------------------------------
   localparam int FLASH_AW = 16; // 64K bytes
   localparam int FLASH_DW = 8;
   localparam int PAGE_AW = 9; // 512-byte pages
   localparam logic [PAGE_AW-1:0] PAGE_LAST = 9'h1ff;
   localparam logic [16:0] FLASH_END_PLUS1 = 17'h10000;
   localparam logic [15:0] FLASH_TOP = 16'hffff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int LDR_UNITS_W = 4; // loader size in 0.5K steps, 0..15

   // ------------------------------------------------------------------
   // Reset values and shipped option defaults
   // ------------------------------------------------------------------
   localparam logic [LDR_UNITS_W-1:0] SHIP_LDR_UNITS = 4'h3; // 1.5K
   localparam logic [15:0] SHIP_LOW_BOUND = 16'hf600; // 1K data region
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_ADDR = 16'h0000;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_READ_DONE = 3'b010,
      ST_PROG = 3'b011,
      ST_ERASE = 3'b100
   } fsp_state_t;
endpackage
`default_nettype wire

// >>> core/fsp_flash_array.sv
// Embedded 64K-byte flash array with program-to-zero and erase ports
`default_nettype none
module fsp_flash_array (
   input wire logic sys_clk_i, // system clock
   input wire logic ce_i, // clock enable, freezes array when low
   input wire logic [15:0] addr_i, // byte address
   input wire logic rd_en_i, // read request
   input wire logic prog_en_i, // byte program request
   input wire logic erase_en_i, // erase one byte to the blank value
   input wire logic [7:0] wdata_i, // program data
   output logic [7:0] rdata_o // read data, one cycle after rd_en_i
);
   logic [fsp_pkg::FLASH_DW-1:0] mem [0:(1<<fsp_pkg::FLASH_AW)-1];
   logic [7:0] rdata_reg;

   // ------------------------------------------------------------------
   // Cell behaviour
   // ------------------------------------------------------------------
   // Programming can only pull bits low; ones come back only by erase
   always_ff @(posedge sys_clk_i) begin
      if (ce_i) begin
         if (erase_en_i) begin
            mem[addr_i] <= fsp_pkg::ERASED_BYTE; // R16
         end else if (prog_en_i) begin
            mem[addr_i] <= mem[addr_i] & wdata_i; // R15
         end
         if (rd_en_i) begin
            rdata_reg <= mem[addr_i];
         end
      end
   end

   assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// >>> core/fsp_sequencer.sv
// Flash self-programming sequencer with partition guard and soft reset
//
// Notes on behaviour
// R01: Loader-region code may erase and program application and data regions.
// R02: Application-region code may modify only the data region.
// R03: Loader size from option: none or 0.5K steps to 7.5K, at top.
// R04: Data region low edge comes from the low-bound register.
// R05: Data region high edge follows the loader start address.
// R06: Low bound loads from option at reset and is software writable.
// R07: All three regions share one 64K-byte flash array.
// R08: Triggers are accepted only while the access enable bit is set.
// R09: Mode codes: 03 erase, 02 program, 01 read.
// R10: High and low address registers form the 16-bit flash address.
// R11: Operation starts only after 46 then B9 written back to back.
// R12: Program writes the data register byte at the address.
// R13: Read completion leaves the flash byte in the data register.
// R14: Software clears enable and sets standby mode after each operation.
// R15: Programming only turns ones into zeros.
// R16: Page erase sets all bits of the page to one.
// R17: Pages are 512 bytes aligned on address bits 8 to 0.
// R18: Software zeroes address bits 8 to 0 for erase.
// R19: CPU stalls until the operation ends, then resumes.
// R20: Writing 001 to control bits 7..5 reboots into application at 0.
// R21: Software should verify by read after program or erase.
// R22: Shipped options: 1.5K loader, 1K data region.
// R23: Data region ends below loader start, or at FFFF without loader.
// R24: Triggers aimed above the data region top are ignored.
// R25: Writing 111 from application region reboots into the loader.
// R26: Broken unlock sequence or cleared enable starts nothing.
// R27: Interrupts during a stall stay pending until it ends.
`default_nettype none
module fsp_sequencer (
   input wire logic sys_clk_i, // system clock, 100 MHz
   input wire logic resetn_i, // asynchronous reset, active low
   input wire logic ce_i, // clock enable, freezes all state but the reset synchronizer when low
   input wire logic [3:0] reg_addr_i, // register address
   input wire logic [7:0] reg_wdata_i, // register write data
   input wire logic reg_wr_i, // register write strobe
   input wire logic reg_rd_i, // register read strobe
   output logic [7:0] reg_rdata_o, // read data, cycle after strobe
   input wire logic exec_in_loader_i, // CPU runs from the loader region
   input wire logic opt_valid_i, // option bytes programmed
   input wire logic [3:0] opt_loader_units_i, // loader size, 0.5K units
   input wire logic [15:0] opt_low_bound_i, // option low bound
   output logic cpu_stall_o, // hold the CPU while flash is busy
   output logic sw_reset_o, // one-cycle software reset request
   output logic boot_loader_o // reboot target: 1 loader, 0 application
);
   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   // Release synchronised to the clock, assertion stays asynchronous
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic opt_loaded;
      logic [fsp_pkg::LDR_UNITS_W-1:0] ldr_units;
      logic [15:0] low_bound;
      logic access_en;
      logic [7:0] mode;
      logic [15:0] addr;
      logic [7:0] data;
      logic armed;
      logic refused;
      fsp_pkg::fsp_state_t state;
      logic [fsp_pkg::PAGE_AW-1:0] cnt;
      logic sw_reset;
      logic boot_loader;
      logic [7:0] rdata;
   } fsp_regs_t;

   fsp_regs_t s_reg;
   fsp_regs_t s_next;

   logic [7:0] fl_rdata;
   logic [15:0] fl_addr;
   logic fl_rd;
   logic fl_prog;
   logic fl_erase;

   // ------------------------------------------------------------------
   // Partition decode
   // ------------------------------------------------------------------
   logic [16:0] ldr_start;
   logic has_loader;
   logic [15:0] data_hi;
   logic in_range;
   logic may_modify;
   logic mode_ok;
   logic is_modify;
   logic cmd_wr;
   logic start;

   // Loader sits at the top; data region ends just beneath it
   always_comb begin
      ldr_start = fsp_pkg::FLASH_END_PLUS1
         - {4'h0, s_reg.ldr_units, 9'h000}; // R03 R05
      has_loader = (s_reg.ldr_units != '0);
      if (has_loader) begin
         data_hi = ldr_start[15:0] - 16'h0001; // R23
      end else begin
         data_hi = fsp_pkg::FLASH_TOP; // R23
      end
   end

   // One shared array, so a region is only an address window
   assign in_range = (s_reg.addr <= data_hi); // R24 R07
   assign is_modify = (s_reg.mode == fsp_pkg::MODE_PROGRAM)
      || (s_reg.mode == fsp_pkg::MODE_ERASE);
   assign mode_ok = is_modify || (s_reg.mode == fsp_pkg::MODE_READ); // R09
   // Loader code reaches application and data; application only data
   assign may_modify = exec_in_loader_i ? in_range // R01
      : (in_range && (s_reg.addr >= s_reg.low_bound)); // R02 R04
   assign cmd_wr = reg_wr_i && (reg_addr_i == fsp_pkg::OFS_CMD);
   // Second unlock byte must follow the first with no other write
   assign start = cmd_wr && (reg_wdata_i == fsp_pkg::CMD_UNLOCK_2)
      && s_reg.armed && s_reg.access_en // R11 R08 R26
      && (s_reg.state == fsp_pkg::ST_IDLE) && mode_ok
      && (is_modify ? may_modify : in_range); // R24

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.sw_reset = 1'b0;
      fl_addr = s_reg.addr; // R10
      fl_rd = 1'b0;
      fl_prog = 1'b0;
      fl_erase = 1'b0;

      // Options are caught once, in the first cycle after release
      if (!s_reg.opt_loaded) begin
         s_next.opt_loaded = 1'b1;
         if (opt_valid_i) begin
            s_next.ldr_units = opt_loader_units_i; // R03
            s_next.low_bound = opt_low_bound_i; // R06
         end else begin
            s_next.ldr_units = fsp_pkg::SHIP_LDR_UNITS; // R22
            s_next.low_bound = fsp_pkg::SHIP_LOW_BOUND; // R22
         end
      end

      // Register writes; any write other than the first key with enable set disarms
      if (reg_wr_i) begin
         s_next.armed = 1'b0; // R26
         case (reg_addr_i)
            fsp_pkg::OFS_CTRL: begin
               if (reg_wdata_i[fsp_pkg::CTRL_CODE_HI:fsp_pkg::CTRL_CODE_LO]
                     == fsp_pkg::SWRST_TO_APP) begin
                  s_next.sw_reset = 1'b1; // R20
                  s_next.boot_loader = 1'b0; // R20
                  s_next.access_en = 1'b0;
               end else if ((reg_wdata_i[fsp_pkg::CTRL_CODE_HI:
                     fsp_pkg::CTRL_CODE_LO] == fsp_pkg::SWRST_TO_LOADER)
                     && !exec_in_loader_i && has_loader) begin
                  s_next.sw_reset = 1'b1; // R25
                  s_next.boot_loader = 1'b1; // R25
                  s_next.access_en = 1'b0;
               end else begin
                  s_next.access_en = reg_wdata_i[fsp_pkg::CTRL_EN_BIT]; // R08
               end
            end
            fsp_pkg::OFS_MODE: s_next.mode = reg_wdata_i; // R09
            fsp_pkg::OFS_ADDR_HI: s_next.addr[15:8] = reg_wdata_i; // R10
            fsp_pkg::OFS_ADDR_LO: s_next.addr[7:0] = reg_wdata_i; // R10
            fsp_pkg::OFS_DATA: s_next.data = reg_wdata_i; // R12
            fsp_pkg::OFS_LB_HI: s_next.low_bound[15:8] = reg_wdata_i; // R06
            fsp_pkg::OFS_LB_LO: s_next.low_bound[7:0] = reg_wdata_i; // R06
            fsp_pkg::OFS_CMD: begin
               // First key arms only with enable set; else it is dropped
               s_next.armed = (reg_wdata_i == fsp_pkg::CMD_UNLOCK_1)
                  && s_reg.access_en; // R11 R26
               if (reg_wdata_i == fsp_pkg::CMD_UNLOCK_2) begin
                  s_next.refused = !start; // R24 R26
               end
            end
            default: ;
         endcase
      end

      // Sequencer; the CPU stays stalled for every busy state
      case (s_reg.state)
         fsp_pkg::ST_IDLE: begin
            if (start) begin
               s_next.cnt = '0;
               case (s_reg.mode)
                  fsp_pkg::MODE_READ: s_next.state = fsp_pkg::ST_READ;
                  fsp_pkg::MODE_PROGRAM: s_next.state = fsp_pkg::ST_PROG;
                  fsp_pkg::MODE_ERASE: s_next.state = fsp_pkg::ST_ERASE;
                  default: s_next.state = fsp_pkg::ST_IDLE;
               endcase
            end
         end
         fsp_pkg::ST_READ: begin
            fl_rd = 1'b1;
            s_next.state = fsp_pkg::ST_READ_DONE;
         end
         fsp_pkg::ST_READ_DONE: begin
            s_next.data = fl_rdata; // R13
            s_next.state = fsp_pkg::ST_IDLE;
         end
         fsp_pkg::ST_PROG: begin
            fl_prog = 1'b1; // R12
            s_next.state = fsp_pkg::ST_IDLE;
         end
         fsp_pkg::ST_ERASE: begin
            // Page base forced, so stray low address bits cannot shift it
            fl_addr = {s_reg.addr[15:fsp_pkg::PAGE_AW], s_reg.cnt}; // R17
            fl_erase = 1'b1; // R16
            s_next.cnt = s_reg.cnt + 9'h001;
            if (s_reg.cnt == fsp_pkg::PAGE_LAST) begin
               s_next.state = fsp_pkg::ST_IDLE;
            end
         end
         default: s_next.state = fsp_pkg::ST_IDLE;
      endcase

      // Read data, presented the cycle after the strobe only
      s_next.rdata = fsp_pkg::RST_BYTE;
      if (reg_rd_i) begin
         case (reg_addr_i)
            fsp_pkg::OFS_CTRL: s_next.rdata = {s_reg.access_en, 7'h00};
            fsp_pkg::OFS_MODE: s_next.rdata = s_reg.mode;
            fsp_pkg::OFS_ADDR_HI: s_next.rdata = s_reg.addr[15:8];
            fsp_pkg::OFS_ADDR_LO: s_next.rdata = s_reg.addr[7:0];
            fsp_pkg::OFS_DATA: s_next.rdata = s_reg.data; // R13
            fsp_pkg::OFS_LB_HI: s_next.rdata = s_reg.low_bound[15:8];
            fsp_pkg::OFS_LB_LO: s_next.rdata = s_reg.low_bound[7:0];
            fsp_pkg::OFS_STATUS: s_next.rdata = {
               s_reg.state != fsp_pkg::ST_IDLE, s_reg.refused,
               s_reg.boot_loader, exec_in_loader_i, s_reg.ldr_units};
            default: s_next.rdata = fsp_pkg::RST_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_reg.opt_loaded <= 1'b0;
         s_reg.ldr_units <= fsp_pkg::SHIP_LDR_UNITS;
         s_reg.low_bound <= fsp_pkg::SHIP_LOW_BOUND;
         s_reg.access_en <= 1'b0;
         s_reg.mode <= fsp_pkg::MODE_STANDBY;
         s_reg.addr <= fsp_pkg::RST_ADDR;
         s_reg.data <= fsp_pkg::RST_BYTE;
         s_reg.armed <= 1'b0;
         s_reg.refused <= 1'b0;
         s_reg.state <= fsp_pkg::ST_IDLE;
         s_reg.cnt <= '0;
         s_reg.sw_reset <= 1'b0;
         s_reg.boot_loader <= 1'b0;
         s_reg.rdata <= fsp_pkg::RST_BYTE;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // Flash array and outputs
   // ------------------------------------------------------------------
   fsp_flash_array u_array (
      .sys_clk_i (sys_clk_i),
      .ce_i (ce_i),
      .addr_i (fl_addr),
      .rd_en_i (fl_rd),
      .prog_en_i (fl_prog),
      .erase_en_i (fl_erase),
      .wdata_i (s_reg.data),
      .rdata_o (fl_rdata)
   );

   // Stall holds the CPU; the interrupt controller sees no acknowledge
   // while held, so its requests simply wait until the stall drops
   assign cpu_stall_o = (s_reg.state != fsp_pkg::ST_IDLE); // R19 R27
   assign sw_reset_o = s_reg.sw_reset;
   assign boot_loader_o = s_reg.boot_loader;
   assign reg_rdata_o = s_reg.rdata;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n);

   AST_START_NEEDS_KEY: assert property ( // R11
      (ce_i && start) |-> s_reg.armed && $past(s_reg.access_en))
      else $error("operation started without unlock key");

   AST_NO_START_DISABLED: assert property ( // R08
      (ce_i && cmd_wr && !s_reg.access_en && !cpu_stall_o)
         |=> !cpu_stall_o)
      else $error("trigger taken while access disabled");

   AST_APP_DATA_ONLY: assert property ( // R02
      (ce_i && $rose(cpu_stall_o) && !$past(exec_in_loader_i)
         && $past(is_modify)) |-> $past(s_reg.addr >= s_reg.low_bound))
      else $error("application modified outside data region");

   AST_ABOVE_TOP: assert property ( // R24
      (ce_i && cmd_wr && !cpu_stall_o && (s_reg.addr > data_hi))
         |=> !cpu_stall_o)
      else $error("trigger above data region was not ignored");

   AST_STALL_ON_START: assert property ( // R19
      (ce_i && start) |=> cpu_stall_o)
      else $error("CPU not stalled after a valid trigger");

   AST_ERASE_END: assert property ( // R17
      (ce_i && s_reg.state == fsp_pkg::ST_ERASE
         && s_reg.cnt == fsp_pkg::PAGE_LAST) |=> !cpu_stall_o)
      else $error("erase did not end after the last page byte");

   AST_ERASE_PAGE: assert property ( // R16
      (ce_i && $rose(cpu_stall_o) && s_reg.state == fsp_pkg::ST_ERASE)
         |-> fl_erase && (fl_addr[fsp_pkg::PAGE_AW-1:0] == '0)
         && (fl_addr[15:fsp_pkg::PAGE_AW] == s_reg.addr[15:fsp_pkg::PAGE_AW]))
      else $error("erase did not begin at the page base");

   AST_READ_DATA: assert property ( // R13
      (ce_i && s_reg.state == fsp_pkg::ST_READ_DONE)
         |=> s_reg.data == $past(fl_rdata) && !cpu_stall_o)
      else $error("read byte not placed in data register");

   AST_PROG_DATA: assert property ( // R12
      fl_prog |-> fl_addr == s_reg.addr && $past(ce_i && start))
      else $error("program outside a started operation");

   AST_SWRST_APP: assert property ( // R20
      (ce_i && reg_wr_i && reg_addr_i == fsp_pkg::OFS_CTRL
         && reg_wdata_i[fsp_pkg::CTRL_CODE_HI:fsp_pkg::CTRL_CODE_LO]
         == fsp_pkg::SWRST_TO_APP)
         |=> sw_reset_o && !boot_loader_o ##1 !sw_reset_o || !ce_i)
      else $error("software reset to application missing");
endmodule
`default_nettype wire

// >>> tb/fsp_flash_model.sv
// Behavioural shadow of the embedded flash array, used for expectations
`default_nettype none
module fsp_flash_model (
   input wire logic sys_clk_i, // system clock
   input wire logic apply_i, // one cycle: commit an operation
   input wire logic [7:0] mode_i, // operation code
   input wire logic [15:0] addr_i, // byte address
   input wire logic [7:0] data_i, // program data
   output logic [7:0] exp_o // expected content at addr_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   // -----------------------------------------------------------------
   // Commit erase or program; unwritten cells stay unknown on purpose
   // -----------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (apply_i && mode_i === fsp_pkg::MODE_ERASE) begin
         for (int i = 0; i < 512; i++) begin
            mem[{addr_i[15:9], 9'h000} + i] = fsp_pkg::ERASED_BYTE;
         end
      end
      if (apply_i && mode_i === fsp_pkg::MODE_PROGRAM) begin
         mem[addr_i] = mem[addr_i] & data_i;
      end
   end
   // Shared array: one store for all three regions
   assign exp_o = mem[addr_i];
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the flash self-programming sequencer
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, resetn, ce, wr, rd, exec, optv, stall, swr, bl, m_apply;
   logic [3:0] addr, optu;
   logic [7:0] wdata, rdata, m_mode, m_data, m_exp, s;
   logic [15:0] optlb, m_addr, a;
   int failures = 0;
   int n_checks = 0;
   integer seed = 32'h39e8936e;
   fsp_sequencer dut (.sys_clk_i(clk), .resetn_i(resetn), .ce_i(ce),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .exec_in_loader_i(exec),
      .opt_valid_i(optv), .opt_loader_units_i(optu),
      .opt_low_bound_i(optlb), .cpu_stall_o(stall), .sw_reset_o(swr),
      .boot_loader_o(bl));
   fsp_flash_model u_flash (.sys_clk_i(clk), .apply_i(m_apply),
      .mode_i(m_mode), .addr_i(m_addr), .data_i(m_data), .exp_o(m_exp));
   // -----------------------------------------------------------------
   // Clock, checks and bus tasks
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out();
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      // An unknown expectation means the cell was never erased
      if (got !== exp || $isunknown(exp)) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Unlock and trigger, then count stall cycles against the expected count cyc
   task automatic trig(input logic [7:0] m, input bit ok, input int cyc);
      int n;
      wr_reg(fsp_pkg::OFS_CMD, fsp_pkg::CMD_UNLOCK_1);
      wr_reg(fsp_pkg::OFS_CMD, fsp_pkg::CMD_UNLOCK_2);
      n = 0;
      #1;
      while (stall === 1'b1 && n < 1000) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 1000) begin
         failures++;
         close_out();
      end
      chk_n(n, ok ? cyc : 0);
   endtask
   task automatic op(input logic [7:0] m, input logic [15:0] ad,
                     input logic [7:0] d, input bit ok, input int cyc);
      logic [7:0] r;
      wr_reg(fsp_pkg::OFS_CTRL, 8'h80);
      wr_reg(fsp_pkg::OFS_MODE, m);
      wr_reg(fsp_pkg::OFS_ADDR_HI, ad[15:8]);
      wr_reg(fsp_pkg::OFS_ADDR_LO, ad[7:0]);
      wr_reg(fsp_pkg::OFS_DATA, d);
      trig(m, ok, cyc);
      rd_reg(fsp_pkg::OFS_STATUS, r);
      chk8({7'h00, r[6]}, {7'h00, !ok});
      m_mode <= m;
      m_addr <= ad;
      m_data <= d;
      m_apply <= ok && m != fsp_pkg::MODE_READ;
      @(posedge clk);
      m_apply <= 1'b0;
      if (ok && m == fsp_pkg::MODE_READ) begin
         rd_reg(fsp_pkg::OFS_DATA, r);
         chk8(r, m_exp);
      end
      wr_reg(fsp_pkg::OFS_CTRL, 8'h00);
      wr_reg(fsp_pkg::OFS_MODE, fsp_pkg::MODE_STANDBY);
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {resetn, ce, wr, rd, exec, optv, m_apply} = 7'b0100100;
      {addr, optu, wdata, optlb} = '0;
      {m_mode, m_data, m_addr} = '0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      // Shipped options: 1.5K loader, low bound F600
      rd_reg(fsp_pkg::OFS_STATUS, s);
      chk8({4'h0, s[3:0]}, 8'h03);
      rd_reg(fsp_pkg::OFS_LB_HI, s);
      chk8(s, 8'hf6);
      rd_reg(4'h9, s);
      chk8(s, 8'h00);
      // Loader code erases and programs the application region
      op(fsp_pkg::MODE_ERASE, 16'h0000, 8'h00, 1, 512);
      for (int i = 0; i < 4; i++) begin
         a = {7'h00, 9'($random(seed))};
         op(fsp_pkg::MODE_PROGRAM, a, 8'($random(seed)), 1, 1);
         op(fsp_pkg::MODE_PROGRAM, a, 8'($random(seed)), 1, 1);
         op(fsp_pkg::MODE_READ, a, 8'h00, 1, 2);
      end
      op(fsp_pkg::MODE_ERASE, 16'hfa00, 8'h00, 0, 0);
      // Application code may touch only the data region
      exec <= 1'b0;
      op(fsp_pkg::MODE_PROGRAM, 16'h0010, 8'h00, 0, 0);
      op(fsp_pkg::MODE_ERASE, 16'hf600, 8'h00, 1, 512);
      // Top byte of the data region lives in the next page up
      op(fsp_pkg::MODE_ERASE, 16'hf800, 8'h00, 1, 512);
      op(fsp_pkg::MODE_PROGRAM, 16'hf9ff, 8'h5a, 1, 1);
      op(fsp_pkg::MODE_READ, 16'hf9ff, 8'h00, 1, 2);
      wr_reg(fsp_pkg::OFS_LB_HI, 8'hf7);
      op(fsp_pkg::MODE_PROGRAM, 16'hf600, 8'h00, 0, 0);
      // Broken unlock and cleared enable start nothing
      wr_reg(fsp_pkg::OFS_CTRL, 8'h80);
      wr_reg(fsp_pkg::OFS_MODE, fsp_pkg::MODE_READ);
      wr_reg(fsp_pkg::OFS_CMD, fsp_pkg::CMD_UNLOCK_1);
      wr_reg(fsp_pkg::OFS_DATA, 8'h00);
      wr_reg(fsp_pkg::OFS_CMD, fsp_pkg::CMD_UNLOCK_2);
      #1 chk8({7'h00, stall}, 8'h00);
      wr_reg(fsp_pkg::OFS_CTRL, 8'h00);
      trig(fsp_pkg::MODE_READ, 0, 0);
      // Software resets: to application, then to loader
      wr_reg(fsp_pkg::OFS_CTRL, 8'h20);
      #1 chk8({6'h00, swr, bl}, 8'h02);
      @(posedge clk);
      #1 chk8({7'h00, swr}, 8'h00);
      wr_reg(fsp_pkg::OFS_CTRL, 8'he0);
      #1 chk8({6'h00, swr, bl}, 8'h03);
      // Mid-run reset with options: no loader, low bound FE00
      @(posedge clk);
      resetn <= 1'b0;
      optv <= 1'b1;
      optlb <= 16'hfe00;
      repeat (2) @(posedge clk);
      #1 chk8({5'h00, stall, swr, bl}, 8'h00);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      rd_reg(fsp_pkg::OFS_LB_HI, s);
      chk8(s, 8'hfe);
      op(fsp_pkg::MODE_ERASE, 16'hfe00, 8'h00, 1, 512);
      op(fsp_pkg::MODE_PROGRAM, 16'hffff, 8'h3c, 1, 1);
      op(fsp_pkg::MODE_READ, 16'hffff, 8'h00, 1, 2);
      // With no loader region a reboot into it must be refused
      wr_reg(fsp_pkg::OFS_CTRL, 8'he0);
      #1 chk8({6'h00, swr, bl}, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
